/* File: logic/crwl_region_lock.sv */
`include "crwl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module crwl_region_lock
  import crwl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // bus request
  input wire crwl_req_s bus_req,
  // bus response
  output crwl_rsp_s bus_rsp_q,
  // guarded register write port
  output logic reg_we_q,
  output crwl_addr_t reg_addr_q,
  output crwl_data_t reg_wdata_q,
  input wire crwl_data_t reg_rdata,
  // status
  output crwl_mask_t locked_q,
  output logic blocked_q
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] lock_index(input crwl_addr_t a);
    crwl_addr_t off;
    off = a - `CRWL_LOCK_BASE;
    return (off[11:2] < 10'd5) ? off[4:2] : 3'h7;
  endfunction

  function automatic logic [2:0] region_index(input crwl_addr_t a);
    crwl_addr_t off;
    off = a - `CRWL_REGION_BASE;
    return (a >= `CRWL_REGION_BASE && off[11:8] < 4'h5) ? off[10:8] : 3'h7;
  endfunction

  function automatic crwl_data_t lock_code(input logic [2:0] i);
    unique case (i)
      3'h0: return `CRWL_LOCK_CODE_0;
      3'h1: return `CRWL_LOCK_CODE_1;
      3'h2: return `CRWL_LOCK_CODE_2;
      3'h3: return `CRWL_LOCK_CODE_3;
      default: return `CRWL_LOCK_CODE_4;
    endcase
  endfunction

  function automatic crwl_data_t unlock_code(input logic [2:0] i);
    unique case (i)
      3'h0: return `CRWL_UNLOCK_CODE_0;
      3'h1: return `CRWL_UNLOCK_CODE_1;
      3'h2: return `CRWL_UNLOCK_CODE_2;
      3'h3: return `CRWL_UNLOCK_CODE_3;
      default: return `CRWL_UNLOCK_CODE_4;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // request classification
  // ---------------------------------------------------------------
  crwl_state_e state_q;
  logic [2:0] lidx;
  logic [2:0] ridx;
  logic take;
  logic is_lock;
  logic is_region;
  logic region_locked;
  logic pad_fault;

  assign lidx = lock_index(bus_req.addr);
  assign ridx = region_index(bus_req.addr);
  assign take = bus_req.valid && state_q == CRWL_IDLE;
  assign is_lock = lidx != 3'h7;
  assign is_region = ridx != 3'h7;
  assign region_locked = is_region && locked_q[ridx];
  assign pad_fault = take && bus_req.write && is_region &&
                     ridx == 3'(`CRWL_PAD_REGION) && region_locked;

  // ---------------------------------------------------------------
  // access state
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CRWL_IDLE;
    end else begin
      unique case (state_q)
        CRWL_IDLE: begin
          if (pad_fault) begin
            state_q <= CRWL_BLOCKED;
          end else if (take) begin
            state_q <= CRWL_RESP;
          end
        end
        CRWL_RESP: state_q <= CRWL_IDLE;
        CRWL_BLOCKED: state_q <= CRWL_BLOCKED;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      blocked_q <= 1'b0;
    end else if (pad_fault) begin
      blocked_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // lock registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      locked_q <= `CRWL_LOCK_RESET;
    end else if (take && bus_req.write && is_lock) begin
      if (bus_req.wdata == lock_code(lidx)) begin
        locked_q[lidx] <= 1'b1;
      end else if (bus_req.wdata == unlock_code(lidx)) begin
        locked_q[lidx] <= 1'b0;
      end
      // other values keep the state
    end
  end

  // ---------------------------------------------------------------
  // guarded write port
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_we_q <= 1'b0;
      reg_addr_q <= '0;
      reg_wdata_q <= '0;
    end else begin
      reg_we_q <= take && bus_req.write && is_region && !region_locked;
      if (take) begin
        reg_addr_q <= bus_req.addr;
        reg_wdata_q <= bus_req.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // response
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rsp_q <= '0;
    end else begin
      bus_rsp_q.ready <= take;
      bus_rsp_q.error <= pad_fault;
      if (take && !bus_req.write && is_lock) begin
        bus_rsp_q.rdata <= locked_q[lidx] ? lock_code(lidx)
                                          : unlock_code(lidx);
      end else begin
        bus_rsp_q.rdata <= '0;
      end
    end
  end

  // region reads are served by the downstream file, unused here
  crwl_data_t rdata_unused;
  assign rdata_unused = reg_rdata;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_fault;
    pad_fault;
  endsequence

  sequence s_dead;
    blocked_q && !bus_rsp_q.ready && !reg_we_q;
  endsequence

  property p_locked_drop;
    @(posedge ref_clk) disable iff (!rst_n)
      take && bus_req.write && region_locked |=> !reg_we_q;
  endproperty
  a_locked_drop: assert property (p_locked_drop)
    else $error("write into locked region reached register file");

  property p_open_write;
    @(posedge ref_clk) disable iff (!rst_n)
      take && bus_req.write && is_region && !region_locked |=> reg_we_q;
  endproperty
  a_open_write: assert property (p_open_write)
    else $error("write into open region was dropped");

  property p_lock5;
    @(posedge ref_clk) disable iff (!rst_n)
      take && bus_req.write && lidx == 3'h4 &&
      bus_req.wdata == `CRWL_LOCK_CODE_4 |=> locked_q[4];
  endproperty
  a_lock5: assert property (p_lock5)
    else $error("fifth region did not lock");

  property p_unlock5;
    @(posedge ref_clk) disable iff (!rst_n)
      take && bus_req.write && lidx == 3'h4 &&
      bus_req.wdata == `CRWL_UNLOCK_CODE_4 |=> !locked_q[4];
  endproperty
  a_unlock5: assert property (p_unlock5)
    else $error("fifth region did not unlock");

  property p_other_keep;
    @(posedge ref_clk) disable iff (!rst_n)
      take && bus_req.write && is_lock &&
      bus_req.wdata != lock_code(lidx) &&
      bus_req.wdata != unlock_code(lidx) |=> $stable(locked_q);
  endproperty
  a_other_keep: assert property (p_other_keep)
    else $error("stray value changed a lock state");

  property p_fault_error;
    @(posedge ref_clk) disable iff (!rst_n)
      s_fault |=> bus_rsp_q.error && bus_rsp_q.ready;
  endproperty
  a_fault_error: assert property (p_fault_error)
    else $error("locked pad write gave no error");

  property p_blocked_forever;
    @(posedge ref_clk) disable iff (!rst_n)
      s_fault |=> ##1 s_dead [*8];
  endproperty
  a_blocked_forever: assert property (p_blocked_forever)
    else $error("control module answered after fault");

  property p_locks_frozen;
    @(posedge ref_clk) disable iff (!rst_n)
      blocked_q |=> $stable(locked_q) && blocked_q;
  endproperty
  a_locks_frozen: assert property (p_locks_frozen)
    else $error("lock state moved while blocked");

  // the error answer is the last ready the bus sees until reset
  property p_no_answer;
    @(posedge ref_clk) disable iff (!rst_n)
      blocked_q && $past(blocked_q) |-> !bus_rsp_q.ready && !reg_we_q;
  endproperty
  a_no_answer: assert property (p_no_answer)
    else $error("blocked control module still answered");

  property p_lock_any;
    @(posedge ref_clk) disable iff (!rst_n)
      take && bus_req.write && is_lock &&
      bus_req.wdata == lock_code(lidx) |=> locked_q[$past(lidx)];
  endproperty
  a_lock_any: assert property (p_lock_any)
    else $error("lock code did not lock its region");

endmodule

`default_nettype wire

/* File: logic/crwl_params.svh */
`ifndef CRWL_PARAMS_SVH
`define CRWL_PARAMS_SVH

// ---------------------------------------------------------------
// geometry
// ---------------------------------------------------------------
`define CRWL_NUM_REGIONS 5
`define CRWL_ADDR_W 12
`define CRWL_DATA_W 32
// region index of the pad configuration region
`define CRWL_PAD_REGION 4

// ---------------------------------------------------------------
// lock register word offsets and region windows
// ---------------------------------------------------------------
`define CRWL_LOCK_BASE 12'h000
`define CRWL_REGION_BASE 12'h100
`define CRWL_REGION_SPAN 12'h100

// ---------------------------------------------------------------
// lock codes
// ---------------------------------------------------------------
`define CRWL_LOCK_CODE_0 32'h1000_a0a0
`define CRWL_UNLOCK_CODE_0 32'h2000_b0b0
`define CRWL_LOCK_CODE_1 32'h1111_a1a1
`define CRWL_UNLOCK_CODE_1 32'h2111_b1b1
`define CRWL_LOCK_CODE_2 32'h1222_a2a2
`define CRWL_UNLOCK_CODE_2 32'h2222_b2b2
`define CRWL_LOCK_CODE_3 32'h1333_a3a3
`define CRWL_UNLOCK_CODE_3 32'h2333_b3b3
`define CRWL_LOCK_CODE_4 32'h143f_832c
`define CRWL_UNLOCK_CODE_4 32'h6f36_1e05

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CRWL_LOCK_RESET 5'h00

`endif

/* File: logic/crwl_pkg.sv */
`default_nettype none

package crwl_pkg;
  typedef logic [11:0] crwl_addr_t;
  typedef logic [31:0] crwl_data_t;
  typedef logic [4:0] crwl_mask_t;

  typedef struct packed {
    logic valid;
    logic write;
    crwl_addr_t addr;
    crwl_data_t wdata;
  } crwl_req_s;

  typedef struct packed {
    logic ready;
    logic error;
    crwl_data_t rdata;
  } crwl_rsp_s;

  typedef enum logic [1:0] {
    CRWL_IDLE,
    CRWL_RESP,
    CRWL_BLOCKED
  } crwl_state_e;
endpackage

`default_nettype wire

/* File: bench/crwl_master.sv */
`timescale 1ns/1ps
`default_nettype none

module crwl_master
  import crwl_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // bus
  output crwl_req_s bus_req,
  input wire crwl_rsp_s bus_rsp_q,
  input wire logic reg_we_q
);
  initial bus_req = '0;

  // ---------------------------------------------------------------
  // one transfer, held until ready or 8 cycles
  // ---------------------------------------------------------------
  task automatic xfer(input logic wr, input crwl_addr_t a,
                      input crwl_data_t d, output logic got,
                      output crwl_rsp_s rsp, output logic we);
    got = 1'b0;
    rsp = '0;
    we = 1'b0;
    @(negedge ref_clk);
    bus_req = '{1'b1, wr, a, d};
    for (int i = 0; i < 8 && !got; i++) begin
      @(negedge ref_clk);
      if (bus_rsp_q.ready === 1'b1) begin
        got = 1'b1;
        rsp = bus_rsp_q;
        we = reg_we_q;
      end
    end
    @(negedge ref_clk);
    // released lines show the inverse, not the last value
    bus_req = '{1'b0, ~wr, ~a, ~d};
  endtask

  // ---------------------------------------------------------------
  // pad update: open the fifth region only around the write
  // ---------------------------------------------------------------
  task automatic pad_update(input crwl_addr_t a, input crwl_data_t d,
                            output logic ok);
    logic got;
    logic we;
    crwl_rsp_s rsp;
    xfer(1'b0, 12'h010, 32'h0000_0000, got, rsp, we);
    if (got && rsp.rdata === 32'h143f_832c) begin
      xfer(1'b1, 12'h010, 32'h6f36_1e05, got, rsp, we);
    end
    xfer(1'b1, a, d, got, rsp, we);
    ok = got && we && !rsp.error;
    xfer(1'b1, 12'h010, 32'h143f_832c, got, rsp, we);
  endtask
endmodule

`default_nettype wire

/* File: bench/test_config_region_write_lock.sv */
`include "crwl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module test_config_region_write_lock
  import crwl_pkg::*;
();
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  crwl_req_s bus_req;
  crwl_rsp_s bus_rsp_q;
  logic reg_we_q;
  crwl_addr_t reg_addr_q;
  crwl_data_t reg_wdata_q;
  crwl_data_t reg_rdata = 32'h5a5a_a5a5;
  crwl_mask_t locked_q;
  logic blocked_q;
  int n_errors = 0;
  int n_compared = 0;
  crwl_data_t lock_code [5] = '{`CRWL_LOCK_CODE_0, `CRWL_LOCK_CODE_1,
    `CRWL_LOCK_CODE_2, `CRWL_LOCK_CODE_3, `CRWL_LOCK_CODE_4};
  crwl_data_t open_code [5] = '{`CRWL_UNLOCK_CODE_0, `CRWL_UNLOCK_CODE_1,
    `CRWL_UNLOCK_CODE_2, `CRWL_UNLOCK_CODE_3, `CRWL_UNLOCK_CODE_4};

  always #5 ref_clk = ~ref_clk;

  crwl_region_lock i_crwl_region_lock (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req),
    .bus_rsp_q(bus_rsp_q), .reg_we_q(reg_we_q), .reg_addr_q(reg_addr_q),
    .reg_wdata_q(reg_wdata_q), .reg_rdata(reg_rdata),
    .locked_q(locked_q), .blocked_q(blocked_q));

  crwl_master i_crwl_master (
    .ref_clk(ref_clk), .bus_req(bus_req), .bus_rsp_q(bus_rsp_q),
    .reg_we_q(reg_we_q));

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic end_of_test;
    if (n_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic region_cycle(input int i);
    logic got;
    logic we;
    crwl_rsp_s rsp;
    crwl_addr_t la;
    crwl_addr_t ra;
    la = crwl_addr_t'(4 * i);
    ra = crwl_addr_t'(256 * (i + 1) + 8);
    i_crwl_master.xfer(1'b1, la, lock_code[i], got, rsp, we);
    check(got && locked_q === crwl_mask_t'(1 << i), "lock");
    i_crwl_master.xfer(1'b0, la, 32'h0000_0000, got, rsp, we);
    check(got && rsp.rdata === lock_code[i], "lock readback");
    i_crwl_master.xfer(1'b1, la, 32'h0000_0001, got, rsp, we);
    check(got && locked_q === crwl_mask_t'(1 << i), "junk code");
    if (i < 4) begin
      i_crwl_master.xfer(1'b1, ra, 32'hdead_0001, got, rsp, we);
      check(got && !we && rsp.error === 1'b0, "locked write");
    end
    i_crwl_master.xfer(1'b1, la, open_code[i], got, rsp, we);
    check(got && locked_q === 5'h00, "unlock");
    i_crwl_master.xfer(1'b1, ra, 32'hbeef_0002, got, rsp, we);
    check(got && we && reg_addr_q === ra, "open write");
    check(reg_wdata_q === 32'hbeef_0002, "open data");
    i_crwl_master.xfer(1'b0, la, 32'h0000_0000, got, rsp, we);
    check(got && rsp.rdata === open_code[i], "unlock readback");
  endtask

  task automatic pad_and_fault;
    logic ok;
    logic got;
    logic we;
    crwl_rsp_s rsp;
    i_crwl_master.pad_update(12'h520, 32'h0000_00a1, ok);
    check(ok && locked_q === 5'h10, "pad update open");
    i_crwl_master.pad_update(12'h524, 32'h0000_00a2, ok);
    // the relock write is the last taken request
    check(ok && reg_addr_q === 12'h010, "pad update locked");
    check(locked_q === 5'h10 && blocked_q === 1'b0, "relocked");
    i_crwl_master.xfer(1'b1, 12'h540, 32'h0000_00ff, got, rsp, we);
    check(got && rsp.error === 1'b1 && !we, "fault error");
    check(blocked_q === 1'b1, "fault blocks");
    i_crwl_master.xfer(1'b0, 12'h000, 32'h0000_0000, got, rsp, we);
    check(!got, "blocked read answered");
    i_crwl_master.xfer(1'b1, 12'h010, open_code[4], got, rsp, we);
    check(!got && blocked_q === 1'b1, "blocked unlock");
  endtask

  task automatic reset_recover;
    logic got;
    logic we;
    crwl_rsp_s rsp;
    @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    check(locked_q === 5'h00 && blocked_q === 1'b0, "reset clears");
    i_crwl_master.xfer(1'b0, 12'h010, 32'h0000_0000, got, rsp, we);
    check(got && rsp.rdata === open_code[4], "answer after reset");
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    check(locked_q === 5'h00 && blocked_q === 1'b0, "reset state");
    for (int i = 0; i < 5; i++) begin
      region_cycle(i);
    end
    pad_and_fault;
    reset_recover;
    end_of_test;
  end
endmodule

`default_nettype wire
